/* shared/rx_gain_pkg.sv */
// constants, register map and state codes of the receive gain control block
package rx_gain_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CONF2      = 4'h0;
   localparam logic [3:0] ADDR_CONF3      = 4'h1;
   localparam logic [3:0] ADDR_CONF4      = 4'h2;
   localparam logic [3:0] ADDR_GAIN_STATE = 4'h3;
   localparam logic [3:0] ADDR_RSSI       = 4'h4;
   localparam logic [3:0] ADDR_CMD        = 4'h5;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CONF2_AGC_EN  = 7;
   localparam int CONF2_AGC_M   = 6;
   localparam int CONF2_AGC_ALG = 5;
   localparam int CONF2_SQM_DYN = 4;
   localparam int CONF3_CLIP    = 1;
   localparam int CONF3_CAP     = 0;
   localparam int CMD_DEFAULT   = 0;
   localparam int CMD_RST_GAIN  = 1;
   localparam int CMD_SQUELCH   = 2;
   localparam int CMD_CLR_RSSI  = 3;
   localparam int CMD_PRESET    = 4;

   // ----------------------------------------------------------------
   // reset and preset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CONF2_RESET  = 8'ha0;
   localparam logic [7:0] CONF3_RESET  = 8'h00;
   localparam logic [7:0] CONF4_RESET  = 8'h00;
   localparam logic [7:0] CONF2_P2P    = 8'ha0;
   localparam logic [7:0] CONF3_P2P    = 8'h03;

   // ----------------------------------------------------------------
   // gain code layout
   // ----------------------------------------------------------------
   localparam logic [3:0] CODE_MIN     = 4'h0;
   localparam logic [3:0] CODE_WIN_MAX = 4'h4;
   localparam logic [3:0] CODE_MAX     = 4'ha;
   localparam logic [2:0] WIN_MAX      = 3'h4;
   localparam logic [2:0] CAP_GAIN_RED = 3'h2;
   localparam logic [3:0] SQ_TRANS_LIM = 4'h2;
   localparam logic [3:0] AGC_PULSES   = 4'h8;
   localparam logic [3:0] RSSI_MAX     = 4'hd;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SQ_DELAY_NS   = 18880;
   localparam int SQ_PERIOD_NS  = 50000;
   localparam int AGC_HOLD_NS   = 1000;
   localparam int SQ_DELAY_CYC  = (SQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SQ_PERIOD_CYC = (SQ_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AGC_HOLD_CYC  = (AGC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // squelch sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SQ_IDLE = 3'b001,
      SQ_WAIT = 3'b010,
      SQ_RUN  = 3'b100
   } sq_state_t;

endpackage

/* shared/rssi_if.sv */
// signals between the gain controller and the signal strength peak holder
`timescale 1ns/1ps
`default_nettype none
interface rssi_if;
   logic             run;
   logic             clr;
   logic [1:0][3:0]  level;
   logic [1:0][3:0]  peak;

   modport ctrl (output run, output clr, output level, input peak);
   modport hold (input run, input clr, input level, output peak);
endinterface
`default_nettype wire

/* verilog/rssi_peak.sv */
// peak hold of the signal strength code for both receive channels
`timescale 1ns/1ps
`default_nettype none
module rssi_peak #(
   parameter int CHANNELS = 2
) (
   input  wire logic clk,
   input  wire logic rst_n,
   rssi_if.hold      rif
);

   // ----------------------------------------------------------------
   // per channel peak hold
   // ----------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
         logic [3:0] peak_q;
         logic [3:0] lvl;
         // codes above the top step are clipped so the display never exceeds it
         assign lvl = (rif.level[ch] > rx_gain_pkg::RSSI_MAX) ? rx_gain_pkg::RSSI_MAX
                                                              : rif.level[ch];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               peak_q <= 4'h0;
            end else if (rif.clr) begin
               peak_q <= 4'h0;
            end else if (rif.run && (lvl > peak_q)) begin
               peak_q <= lvl;
            end
         end
         assign rif.peak[ch] = peak_q;
      end
   endgenerate

endmodule
`default_nettype wire

/* verilog/rx_gain_ctrl.sv */
// receiver gain, squelch and signal strength control with its registers
// How it works
// - digitizer window has five 3 dB settings, from loops or configuration four
// - eleven gain codes: 0 min window, four window steps, six gain cuts
// - squelch starts from the initial code in configuration four, the gain loop from 4h or the squelch code
// - falling receive-active latches the current code into the gain state register
// - squelch counts digitizer edges per 50 us; more than two steps gain
// - reset-receive-gain command clears accumulated squelch reduction
// - dynamic squelch starts 18.88 us after transmit end, ends on mask timer
// - squelch command accepted only while receive-active is low
// - gain loop starts on receive-active rise, resets when it falls
// - gain loop steps down while its wider comparator shows transitions
// - configuration two holds gain loop enable, mode and algorithm bits
// - mode bit: act all reception or first eight sub-carrier pulses only
// - algorithm bit: start from preset code 4h or from the squelch code, which starts at the initial code
// - reset state: loop enabled, whole reception, preset algorithm
// - signal strength measured while receive-active high, frozen while low
// - signal strength is peak hold, zeroed whenever the gain loop steps
// - signal strength is a 4-bit code of 2.8 dB steps, at most Dh
// - clear-signal-strength command zeroes and restarts the peak hold
// - clip bit in configuration three enables the limiting circuits
// - peer-to-peer gain cap forces -6 dB gain cut and maximum window
// - analog preset in active peer-to-peer mode loads the receiver settings
// - reset-receive-gain loads configuration four into the loop shadow registers
`timescale 1ns/1ps
`default_nettype none
module rx_gain_ctrl #(
   parameter int SQ_PERIOD_CYC = rx_gain_pkg::SQ_PERIOD_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rdata,
   input  wire logic       rx_on,
   input  wire logic       tx_end,
   input  wire logic       mask_rx_expired,
   input  wire logic       active_p2p_mode,
   input  wire logic       dig_out,
   input  wire logic       agc_cmp_out,
   input  wire logic       subc_pulse,
   input  wire logic [3:0] rssi_am_level,
   input  wire logic [3:0] rssi_pm_level,
   output logic      [2:0] dig_window,
   output logic      [2:0] gain23_red,
   output logic      [3:0] gain_code,
   output logic            clip_en,
   output logic            peer_to_peer_gain_cap,
   output logic            squelch_active
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   logic rst_int_n;
   assign rst_int_n = rst_s2_q;

   // ----------------------------------------------------------------
   // register writes and commands
   // ----------------------------------------------------------------
   logic [7:0] conf2_q;
   logic [7:0] conf3_q;
   logic [7:0] conf4_q;
   logic       cmd_wr;
   logic       soft_def;
   logic       rst_gain;
   logic       sq_cmd;
   logic       clr_rssi;
   logic       preset;
   assign cmd_wr   = wr_en && (addr == rx_gain_pkg::ADDR_CMD);
   assign soft_def = cmd_wr && wdata[rx_gain_pkg::CMD_DEFAULT];
   assign rst_gain = cmd_wr && wdata[rx_gain_pkg::CMD_RST_GAIN];
   assign sq_cmd   = cmd_wr && wdata[rx_gain_pkg::CMD_SQUELCH] && !rx_on;
   assign clr_rssi = cmd_wr && wdata[rx_gain_pkg::CMD_CLR_RSSI];
   // preset only has a defined target in active peer-to-peer mode
   assign preset   = cmd_wr && wdata[rx_gain_pkg::CMD_PRESET] && active_p2p_mode;

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         conf2_q <= rx_gain_pkg::CONF2_RESET;
         conf3_q <= rx_gain_pkg::CONF3_RESET;
         conf4_q <= rx_gain_pkg::CONF4_RESET;
      end else if (soft_def) begin
         conf2_q <= rx_gain_pkg::CONF2_RESET;
         conf3_q <= rx_gain_pkg::CONF3_RESET;
         conf4_q <= rx_gain_pkg::CONF4_RESET;
      end else if (preset) begin
         conf2_q <= rx_gain_pkg::CONF2_P2P;
         conf3_q <= rx_gain_pkg::CONF3_P2P;
      end else if (wr_en) begin
         if (addr == rx_gain_pkg::ADDR_CONF2) begin
            conf2_q <= {wdata[7:4], 4'h0};
         end else if (addr == rx_gain_pkg::ADDR_CONF3) begin
            conf3_q <= {6'h00, wdata[1:0]};
         end else if (addr == rx_gain_pkg::ADDR_CONF4) begin
            conf4_q <= {4'h0, wdata[3:0]};
         end
      end
   end

   logic       agc_en;
   logic       agc_m;
   logic       agc_alg;
   logic       sqm_dyn;
   logic [3:0] init_code;
   assign agc_en   = conf2_q[rx_gain_pkg::CONF2_AGC_EN];
   assign agc_m    = conf2_q[rx_gain_pkg::CONF2_AGC_M];
   assign agc_alg  = conf2_q[rx_gain_pkg::CONF2_AGC_ALG];
   assign sqm_dyn  = conf2_q[rx_gain_pkg::CONF2_SQM_DYN];
   // out of range initial codes behave as the top code
   assign init_code = (conf4_q[3:0] > rx_gain_pkg::CODE_MAX) ? rx_gain_pkg::CODE_MAX
                                                             : conf4_q[3:0];

   // ----------------------------------------------------------------
   // input edges
   // ----------------------------------------------------------------
   logic rx_prev_q;
   logic dig_prev_q;
   logic agc_prev_q;
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         rx_prev_q  <= 1'b0;
         dig_prev_q <= 1'b0;
         agc_prev_q <= 1'b0;
      end else begin
         rx_prev_q  <= rx_on;
         dig_prev_q <= dig_out;
         agc_prev_q <= agc_cmp_out;
      end
   end
   logic rx_rise;
   logic rx_fall;
   logic dig_edge;
   logic agc_edge;
   assign rx_rise  = rx_on && !rx_prev_q;
   assign rx_fall  = !rx_on && rx_prev_q;
   assign dig_edge = dig_out ^ dig_prev_q;
   assign agc_edge = agc_cmp_out ^ agc_prev_q;

   // ----------------------------------------------------------------
   // squelch sequencer
   // ----------------------------------------------------------------
   rx_gain_pkg::sq_state_t sq_state_q;
   logic [13:0] sq_cnt_q;
   logic [3:0]  sq_trans_q;
   logic [3:0]  sq_code_q;
   logic [3:0]  base_q;
   logic        period_end;
   logic        sq_step;
   assign period_end = (sq_state_q == rx_gain_pkg::SQ_RUN) &&
                       (sq_cnt_q == 14'(SQ_PERIOD_CYC - 1));
   assign sq_step    = period_end && (sq_trans_q > rx_gain_pkg::SQ_TRANS_LIM) &&
                       (sq_code_q < rx_gain_pkg::CODE_MAX);

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sq_state_q <= rx_gain_pkg::SQ_IDLE;
         sq_cnt_q   <= 14'h0000;
      end else if (soft_def) begin
         sq_state_q <= rx_gain_pkg::SQ_IDLE;
         sq_cnt_q   <= 14'h0000;
      end else begin
         case (sq_state_q)
            rx_gain_pkg::SQ_IDLE: begin
               sq_cnt_q <= 14'h0000;
               if (sq_cmd) begin
                  sq_state_q <= rx_gain_pkg::SQ_RUN;
               end else if (tx_end && sqm_dyn) begin
                  sq_state_q <= rx_gain_pkg::SQ_WAIT;
               end
            end
            rx_gain_pkg::SQ_WAIT: begin
               if (mask_rx_expired) begin
                  sq_state_q <= rx_gain_pkg::SQ_IDLE;
                  sq_cnt_q   <= 14'h0000;
               end else if (sq_cnt_q == 14'(rx_gain_pkg::SQ_DELAY_CYC - 1)) begin
                  sq_state_q <= rx_gain_pkg::SQ_RUN;
                  sq_cnt_q   <= 14'h0000;
               end else begin
                  sq_cnt_q <= sq_cnt_q + 14'h0001;
               end
            end
            rx_gain_pkg::SQ_RUN: begin
               if (mask_rx_expired) begin
                  sq_state_q <= rx_gain_pkg::SQ_IDLE;
                  sq_cnt_q   <= 14'h0000;
               end else if (period_end) begin
                  sq_cnt_q <= 14'h0000;
                  if (!sq_step) begin
                     sq_state_q <= rx_gain_pkg::SQ_IDLE;
                  end
               end else begin
                  sq_cnt_q <= sq_cnt_q + 14'h0001;
               end
            end
            default: begin
               sq_state_q <= rx_gain_pkg::SQ_IDLE;
               sq_cnt_q   <= 14'h0000;
            end
         endcase
      end
   end

   // edges counted per period, saturating since only "more than two" matters
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sq_trans_q <= 4'h0;
      end else if ((sq_state_q != rx_gain_pkg::SQ_RUN) || period_end) begin
         sq_trans_q <= 4'h0;
      end else if (dig_edge && (sq_trans_q <= rx_gain_pkg::SQ_TRANS_LIM)) begin
         sq_trans_q <= sq_trans_q + 4'h1;
      end
   end

   // shadow of the initial code and the squelch result
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         base_q    <= rx_gain_pkg::CODE_MIN;
         sq_code_q <= rx_gain_pkg::CODE_MIN;
      end else if (soft_def) begin
         base_q    <= rx_gain_pkg::CODE_MIN;
         sq_code_q <= rx_gain_pkg::CODE_MIN;
      end else if (rst_gain) begin
         base_q    <= init_code;
         sq_code_q <= init_code;
      end else if (sq_step) begin
         sq_code_q <= sq_code_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // gain loop
   // ----------------------------------------------------------------
   logic [3:0]  pulse_cnt_q;
   logic [13:0] hold_q;
   logic        agc_run;
   logic        agc_step;
   logic        agc_step_q;
   logic [3:0]  agc_start;
   assign agc_run   = rx_on && rx_prev_q && agc_en && (hold_q == 14'h0000) &&
                      (!agc_m || (pulse_cnt_q < rx_gain_pkg::AGC_PULSES));
   assign agc_step  = agc_run && agc_edge &&
                      (gain_code < rx_gain_pkg::CODE_MAX);
   // preset start never lowers a code that squelch or the initial setting gave
   // squelch only ever raises its code above the shadowed initial code
   assign agc_start = (agc_alg && (sq_code_q < rx_gain_pkg::CODE_WIN_MAX)) ?
                      rx_gain_pkg::CODE_WIN_MAX :
                      ((sq_code_q < base_q) ? base_q : sq_code_q);

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         pulse_cnt_q <= 4'h0;
      end else if (!rx_on) begin
         pulse_cnt_q <= 4'h0;
      end else if (subc_pulse && (pulse_cnt_q < rx_gain_pkg::AGC_PULSES)) begin
         pulse_cnt_q <= pulse_cnt_q + 4'h1;
      end
   end

   // settle time after each step so one overload does not cascade to the bottom
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         hold_q <= 14'h0000;
      end else if (!rx_on) begin
         hold_q <= 14'h0000;
      end else if (agc_step) begin
         hold_q <= 14'(rx_gain_pkg::AGC_HOLD_CYC);
      end else if (hold_q != 14'h0000) begin
         hold_q <= hold_q - 14'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         agc_step_q <= 1'b0;
      end else begin
         agc_step_q <= agc_step;
      end
   end

   // ----------------------------------------------------------------
   // live gain code and latched state
   // ----------------------------------------------------------------
   logic [3:0] gain_state_q;
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         gain_code <= rx_gain_pkg::CODE_MIN;
      end else if (!rx_on || soft_def) begin
         gain_code <= soft_def ? rx_gain_pkg::CODE_MIN : sq_code_q;
      end else if (rx_rise) begin
         gain_code <= agc_en ? agc_start : sq_code_q;
      end else if (agc_step) begin
         gain_code <= gain_code + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         gain_state_q <= rx_gain_pkg::CODE_MIN;
      end else if (soft_def) begin
         gain_state_q <= rx_gain_pkg::CODE_MIN;
      end else if (rx_fall) begin
         gain_state_q <= gain_code;
      end
   end

   // ----------------------------------------------------------------
   // analog settings
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         dig_window            <= 3'h0;
         gain23_red            <= 3'h0;
         clip_en               <= 1'b0;
         peer_to_peer_gain_cap <= 1'b0;
         squelch_active        <= 1'b0;
      end else begin
         clip_en               <= conf3_q[rx_gain_pkg::CONF3_CLIP];
         peer_to_peer_gain_cap <= conf3_q[rx_gain_pkg::CONF3_CAP];
         squelch_active        <= (sq_state_q == rx_gain_pkg::SQ_RUN);
         if (conf3_q[rx_gain_pkg::CONF3_CAP]) begin
            dig_window <= rx_gain_pkg::WIN_MAX;
            gain23_red <= rx_gain_pkg::CAP_GAIN_RED;
         end else if (gain_code > rx_gain_pkg::CODE_WIN_MAX) begin
            dig_window <= rx_gain_pkg::WIN_MAX;
            gain23_red <= 3'(gain_code - rx_gain_pkg::CODE_WIN_MAX);
         end else begin
            dig_window <= gain_code[2:0];
            gain23_red <= 3'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // signal strength
   // ----------------------------------------------------------------
   rssi_if rif ();
   assign rif.run      = rx_on;
   assign rif.clr      = rx_rise || agc_step_q || clr_rssi || soft_def;
   assign rif.level[0] = rssi_am_level;
   assign rif.level[1] = rssi_pm_level;

   rssi_peak #(
      .CHANNELS (2)
   ) u_rssi (
      .clk   (core_clk),
      .rst_n (rst_int_n),
      .rif   (rif.hold)
   );

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         rdata <= 8'h00;
      end else if (!rd_en) begin
         rdata <= 8'h00;
      end else if (addr == rx_gain_pkg::ADDR_CONF2) begin
         rdata <= conf2_q;
      end else if (addr == rx_gain_pkg::ADDR_CONF3) begin
         rdata <= conf3_q;
      end else if (addr == rx_gain_pkg::ADDR_CONF4) begin
         rdata <= conf4_q;
      end else if (addr == rx_gain_pkg::ADDR_GAIN_STATE) begin
         rdata <= {4'h0, gain_state_q};
      end else if (addr == rx_gain_pkg::ADDR_RSSI) begin
         rdata <= {rif.peak[0], rif.peak[1]};
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

/* bench/rx_gain_sva.sv */
// port assertions of the receive gain controller
`timescale 1ns/1ps
`default_nettype none
module rx_gain_sva #(
   parameter int SQ_PERIOD_CYC = 10
) (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       wr_en,
   input wire logic       rx_on,
   input wire logic       mask_rx_expired,
   input wire logic [3:0] addr,
   input wire logic [3:0] gain_code,
   input wire logic [7:0] wdata,
   input wire logic [2:0] dig_window,
   input wire logic [2:0] gain23_red,
   input wire logic       clip_en,
   input wire logic       peer_to_peer_gain_cap,
   input wire logic       squelch_active
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   window_map_a:
   assert property (gain_code <= 4'h4 ##1 !peer_to_peer_gain_cap |->
      dig_window == $past(gain_code[2:0]) && gain23_red == 3'h0) else $error("window wrong");
   gain_cut_map_a:
   assert property (gain_code > 4'h4 ##1 !peer_to_peer_gain_cap |-> dig_window == 3'h4
      && gain23_red == $past(gain_code[2:0]) - 3'h4) else $error("gain cut wrong");
   cap_force_a:
   assert property (peer_to_peer_gain_cap |-> dig_window == rx_gain_pkg::WIN_MAX
      && gain23_red == rx_gain_pkg::CAP_GAIN_RED) else $error("cap not forced");
   code_range_a:
   assert property (gain_code <= rx_gain_pkg::CODE_MAX) else $error("code beyond max");
   agc_single_step_a:
   assert property (rx_on [*3] |-> gain_code >= $past(gain_code)
      && {1'b0, gain_code} <= {1'b0, $past(gain_code)} + 5'h1) else $error("bad step");
   squelch_refused_a:
   assert property (rx_on && wr_en && addr == rx_gain_pkg::ADDR_CMD && wdata[2]
      && !squelch_active |=> ##1 !squelch_active) else $error("squelch taken");
   mask_end_a:
   assert property (mask_rx_expired |=> ##1 !squelch_active) else $error("squelch kept");
   clip_write_a:
   assert property (wr_en && addr == rx_gain_pkg::ADDR_CONF3 |=> ##1
      clip_en == $past(wdata[rx_gain_pkg::CONF3_CLIP], 2)) else $error("clip wrong");
   cover property ($rose(squelch_active));
   cover property (gain_code == rx_gain_pkg::CODE_MAX);
   cover property (peer_to_peer_gain_cap);
endmodule
bind rx_gain_ctrl rx_gain_sva #(.SQ_PERIOD_CYC(SQ_PERIOD_CYC)) sva_i (.*);
`default_nettype wire

/* bench/rx_chain_model.sv */
// digitizer and gain loop comparator outputs of the analog chain
`timescale 1ns/1ps
`default_nettype none
module rx_chain_model (
   input  wire logic core_clk,
   input  wire logic noise_en,
   input  wire logic agc_kick,
   output logic      dig_out,
   output logic      agc_cmp_out
);
   logic [2:0] div_q = 3'h0;
   initial dig_out = 1'b0;
   initial agc_cmp_out = 1'b0;
   // a change every eight cycles keeps each period well above two changes
   always @(posedge core_clk) begin
      div_q <= div_q + 3'h1;
      if (noise_en && div_q == 3'h7) dig_out <= !dig_out;
      if (agc_kick) agc_cmp_out <= !agc_cmp_out;
   end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench of the receive gain controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int PER = 50;
   logic core_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, rx_on = 0, tx_end = 0;
   logic mask_rx_expired = 0, active_p2p_mode = 0, noise_en = 0, agc_kick = 0;
   logic subc_pulse = 0, dig_out, agc_cmp_out, clip_en, peer_to_peer_gain_cap;
   logic [3:0] addr = 0, rssi_am_level = 0, rssi_pm_level = 0, gain_code;
   logic [7:0] wdata = 0, rdata;
   logic [2:0] dig_window, gain23_red;
   logic       squelch_active;
   int         n_errors = 0, n_compared = 0, cyc = 0;
   always #2.5 core_clk = ~core_clk;
   rx_gain_ctrl #(.SQ_PERIOD_CYC(PER)) DUT (.*);
   rx_chain_model model_i (.*);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] exp, input logic [7:0] got, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      wt(1);
      wr_en <= 1'b0;
      wt(1);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      addr <= a;
      rd_en <= 1'b1;
      wt(1);
      rd_en <= 1'b0;
      check(exp, rdata, "rdata");
      wt(1);
   endtask
   task automatic kick;
      agc_kick <= 1'b1;
      wt(1);
      agc_kick <= 1'b0;
      wt(4);
   endtask
   task automatic code(input logic [3:0] exp);
      check({4'h0, exp}, {4'h0, gain_code}, "gain_code");
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run;
      end
   end
   initial begin
      wt(20);
      rst_n <= 1'b1;
      wt(5);
      for (int i = 0; i < 6; i++) rd(4'(i), i == 0 ? 8'ha0 : 8'h00);
      rd(4'hf, 8'h00);
      wr(4'h1, 8'h03);
      wt(3);
      check(8'he2, {clip_en, peer_to_peer_gain_cap, dig_window, gain23_red}, "limits");
      wr(4'h1, 8'h00);
      $display("test registers done");
      rx_on <= 1'b1;
      rssi_am_level <= 4'hf;
      rssi_pm_level <= 4'h5;
      wt(5);
      code(4'h4);
      rd(4'h4, 8'hd5);
      rssi_am_level <= 4'h0;
      rssi_pm_level <= 4'h0;
      kick;
      kick;
      wt(300);
      code(4'h5);
      rd(4'h4, 8'h00);
      kick;
      rssi_am_level <= 4'h3;
      rssi_pm_level <= 4'h2;
      wt(5);
      rd(4'h4, 8'h32);
      rssi_am_level <= 4'h0;
      wr(4'h5, 8'h08);
      rd(4'h4, 8'h02);
      rx_on <= 1'b0;
      rssi_pm_level <= 4'h9;
      wt(3);
      rd(4'h3, 8'h06);
      rd(4'h4, 8'h02);
      code(4'h0);
      wr(4'h0, 8'h80);
      rx_on <= 1'b1;
      wt(3);
      code(4'h0);
      kick;
      code(4'h1);
      rx_on <= 1'b0;
      wr(4'h0, 8'h00);
      rx_on <= 1'b1;
      kick;
      code(4'h0);
      rx_on <= 1'b0;
      wr(4'h0, 8'hc0);
      rx_on <= 1'b1;
      kick;
      code(4'h1);
      repeat (8) begin
         subc_pulse <= 1'b1;
         wt(1);
         subc_pulse <= 1'b0;
         wt(1);
      end
      wt(200);
      kick;
      code(4'h1);
      rx_on <= 1'b0;
      $display("test gain loop done");
      wr(4'h5, 8'h04);
      noise_en <= 1'b1;
      wt(PER * 13);
      code(4'ha);
      noise_en <= 1'b0;
      wr(4'h2, 8'h03);
      wr(4'h5, 8'h02);
      wt(3);
      code(4'h3);
      rx_on <= 1'b1;
      wt(2);
      wr(4'h5, 8'h04);
      wt(3);
      check(8'h00, {7'h0, squelch_active}, "squelch_active");
      rx_on <= 1'b0;
      wr(4'h0, 8'h10);
      tx_end <= 1'b1;
      wt(1);
      tx_end <= 1'b0;
      wt(3770);
      check(8'h00, {7'h0, squelch_active}, "squelch_active");
      wt(15);
      check(8'h01, {7'h0, squelch_active}, "squelch_active");
      mask_rx_expired <= 1'b1;
      wt(1);
      mask_rx_expired <= 1'b0;
      wt(3);
      check(8'h00, {7'h0, squelch_active}, "squelch_active");
      $display("test squelch done");
      active_p2p_mode <= 1'b1;
      wr(4'h5, 8'h10);
      rd(4'h1, 8'h03);
      wr(4'h5, 8'h01);
      rd(4'h1, 8'h00);
      $display("test preset done");
      complete_run;
   end
endmodule
`default_nettype wire
